//--- core/art_pkg.sv
// Purpose: Constants and types shared by the auto-reload PWM/capture timer.
// Assumes: APB byte address is four times the register index.
// Notes:   Field positions and reset values live here only.
package art_pkg;
	// ************************************************************
	// Register indices and bus
	// ************************************************************
	localparam int unsigned AW = 10;
	localparam int unsigned DW = 32;
	localparam logic [7:0] IDX_MODE_CTRL = 8'hd5;
	localparam logic [7:0] IDX_FLAGS     = 8'hd6;
	localparam logic [7:0] IDX_CLK_CFG   = 8'hd7;
	localparam logic [7:0] IDX_RELOAD    = 8'hd9;
	localparam logic [7:0] IDX_COMPARE   = 8'hda;
	localparam logic [7:0] IDX_LOAD      = 8'hdb;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int unsigned MC_LOAD  = 7;
	localparam int unsigned MC_TEN   = 6;
	localparam int unsigned MC_PWMOE = 5;
	localparam int unsigned MC_EIE   = 4;
	localparam int unsigned MC_COMPARE_IRQ_ENABLE  = 3;
	localparam int unsigned MC_OVERFLOW_IRQ_ENABLE  = 2;
	localparam int unsigned FL_EF    = 2;
	localparam int unsigned FL_CPF   = 1;
	localparam int unsigned FL_OVF   = 0;
	localparam int unsigned CC_PS_LO = 5;
	localparam int unsigned CC_POL   = 3;
	localparam int unsigned CC_EDGE  = 2;
	localparam logic [7:0] MC_RD_MASK = 8'h7f;
	localparam logic [7:0] CC_WR_MASK = 8'hef;
	// ************************************************************
	// Reset values and counts
	// ************************************************************
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [6:0] RST_PSC   = 7'h00;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic [7:0] CNT_TOP   = 8'hff;
	localparam logic [1:0] DIV3_LAST = 2'h2;
	localparam logic [1:0] DIV3_ZERO = 2'h0;
	localparam logic [6:0] PSC_ONE   = 7'h01;
	localparam logic [7:0] CNT_ONE   = 8'h01;
	localparam logic [1:0] DIV3_ONE  = 2'h1;

	typedef enum logic [1:0] {
		MODE_AUTO   = 2'h0,
		MODE_CAP    = 2'h1,
		MODE_CAPRST = 2'h2,
		MODE_EXTLD  = 2'h3
	} art_mode_t;

	typedef enum logic [1:0] {
		SRC_INT  = 2'h0,
		SRC_DIV3 = 2'h1,
		SRC_PIN  = 2'h2,
		SRC_RSVD = 2'h3
	} art_src_t;

	typedef struct packed {
		logic [7:0]  mode_ctrl;
		logic [7:0]  clk_cfg;
		logic [2:0]  flags;
		logic [7:0]  reload;
		logic [7:0]  compare;
		logic [7:0]  cnt;
		logic [6:0]  psc;
		logic [1:0]  div3;
		logic [2:0]  pin_sync;
		logic        pwm;
		logic [31:0] prdata;
	} art_state_t;
endpackage : art_pkg

//--- core/art_timer.sv
// Purpose: 8-bit auto-reload timer with prescaler, PWM, capture and load modes.
// Assumes: APB slave with zero wait states; timer pin synchronous sampling.
// Notes:   Counter is reached through the load register and the mode register's load command bit.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns

// Summary of operation
// - Counter is an 8-bit up-counter stepping on each prescaled tick.
// - Clock source is internal clock, internal clock divided by 3, or pin.
// - 7-bit prescaler with eight taps divides by 2 to the n.
// - Enable low freezes prescaler and counter; high lets them count.
// - System reset clears the counter.
// - Writing the load register copies the value into the counter at once.
// - Reading the load register returns the live count; no direct counter access.
// - Every counter load also clears the prescaler.
// - Auto-reload: overflow reloads and sets PWM; compare match clears PWM.
// - Overflow sets a sticky flag; flag with its enable requests interrupt.
// - Compare match sets a sticky flag; flag with its enable requests interrupt.
// - Capture mode: active pin edge copies count and sets external flag.
// - Capture and load modes free-run; overflow sets, match clears PWM.
// - Capture-with-reset mode also clears counter and prescaler on capture.
// - External-load mode: active pin edge loads reload value into counter.
// - Writing 06h to flags clears overflow only, external flag kept.
// - Timer wakes from wait on any source, from stop only on pin clock.
// - Writing zero clears a flag; writing one leaves it unchanged.
// - Clock select codes: internal, divided by 3, pin, fourth reserved.
// - Edge enable zero disables detection; polarity zero rising, one falling.
// - Mode codes: auto-reload, capture, capture with reset, external load.
module art_timer
	import art_pkg::*;
(
	// Clock and reset.
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// APB slave.
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [art_pkg::AW-1:0] paddr_i,
	input  wire logic [art_pkg::DW-1:0] pwdata_i,
	output logic      [art_pkg::DW-1:0] prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Timer pins.
	input  wire logic                  timer_input_pin_i,
	output logic                       pwm_output_pin_o,
	output logic                       pwm_output_pin_oe_o,
	// Core power state and requests.
	input  wire logic                  wait_mode_i,
	input  wire logic                  stop_mode_i,
	output logic                       irq_o,
	output logic                       wake_o
);
	import art_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [AW-1:0] addr_of(input logic [7:0] idx);
		addr_of = {idx, 2'b00};
	endfunction

	function automatic logic is_mapped(input logic [AW-1:0] a);
		is_mapped = (a == addr_of(IDX_MODE_CTRL)) || (a == addr_of(IDX_FLAGS)) ||
			(a == addr_of(IDX_CLK_CFG)) || (a == addr_of(IDX_RELOAD)) ||
			(a == addr_of(IDX_COMPARE)) || (a == addr_of(IDX_LOAD));
	endfunction

	art_state_t s_q;
	art_state_t s_d;

	logic       acc;
	logic       wr;
	logic       wr_mode;
	logic       wr_flags;
	logic       wr_load;
	logic       do_cmd_load;
	logic       src_tick;
	logic       tick;
	logic       ovf_ev;
	logic       cmp_ev;
	logic       edge_ev;
	logic       pin_rise;
	logic       pin_fall;
	logic [6:0] tap_mask;
	logic [7:0] cnt_step;
	art_mode_t  mode;
	art_src_t   src;
	logic [7:0] rd_byte;

	assign mode = art_mode_t'(s_q.mode_ctrl[1:0]);
	assign src  = art_src_t'(s_q.clk_cfg[1:0]);

	// ************************************************************
	// Bus decode
	// ************************************************************
	assign acc         = psel_i && penable_i;
	assign wr          = acc && pwrite_i;
	assign wr_mode     = wr && (paddr_i == addr_of(IDX_MODE_CTRL));
	assign wr_flags    = wr && (paddr_i == addr_of(IDX_FLAGS));
	assign wr_load     = wr && (paddr_i == addr_of(IDX_LOAD));
	assign do_cmd_load = wr_mode && pwdata_i[MC_LOAD];
	assign pready_o    = 1'b1;
	assign pslverr_o   = acc && !is_mapped(paddr_i);

	always_comb begin
		if (paddr_i == addr_of(IDX_MODE_CTRL)) begin
			rd_byte = s_q.mode_ctrl & MC_RD_MASK;
		end else if (paddr_i == addr_of(IDX_FLAGS)) begin
			rd_byte = {5'h00, s_q.flags};
		end else if (paddr_i == addr_of(IDX_CLK_CFG)) begin
			rd_byte = s_q.clk_cfg & CC_WR_MASK;
		end else if (paddr_i == addr_of(IDX_RELOAD)) begin
			rd_byte = s_q.reload;
		end else if (paddr_i == addr_of(IDX_COMPARE)) begin
			rd_byte = s_q.compare;
		end else if (paddr_i == addr_of(IDX_LOAD)) begin
			rd_byte = s_q.cnt;
		end else begin
			rd_byte = RST_BYTE;
		end
	end

	// ************************************************************
	// Clock source, prescaler and edge events
	// ************************************************************
	// Only the second and third sync stages feed the edge detectors.
	assign pin_rise = s_q.pin_sync[1] && !s_q.pin_sync[2];
	assign pin_fall = !s_q.pin_sync[1] && s_q.pin_sync[2];

	// In stop mode the internal sources are frozen; only the pin keeps ticking.
	always_comb begin
		case (src)
			SRC_INT:  src_tick = !stop_mode_i;
			SRC_DIV3: src_tick = !stop_mode_i && (s_q.div3 == DIV3_LAST);
			SRC_PIN:  src_tick = pin_rise;
			default:  src_tick = 1'b0;
		endcase
	end

	assign tap_mask = 7'((8'h01 << s_q.clk_cfg[7:CC_PS_LO]) - 8'h01);
	assign tick     = s_q.mode_ctrl[MC_TEN] && src_tick &&
		((s_q.psc & tap_mask) == tap_mask);
	assign ovf_ev   = tick && (s_q.cnt == CNT_TOP);
	assign cnt_step = (ovf_ev && mode == MODE_AUTO) ? s_q.reload : 8'(s_q.cnt + CNT_ONE);
	assign cmp_ev   = tick && (cnt_step == s_q.compare);
	assign edge_ev  = s_q.clk_cfg[CC_EDGE] &&
		(s_q.clk_cfg[CC_POL] ? pin_fall : pin_rise);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.pin_sync = {s_q.pin_sync[1:0], timer_input_pin_i};
		if (!stop_mode_i) begin
			s_d.div3 = (s_q.div3 == DIV3_LAST) ? DIV3_ZERO : 2'(s_q.div3 + DIV3_ONE);
		end

		// Prescaler and counter stepping.
		if (s_q.mode_ctrl[MC_TEN] && src_tick) begin
			s_d.psc = 7'(s_q.psc + PSC_ONE);
		end
		if (tick) begin
			s_d.cnt = cnt_step;
			if (ovf_ev && mode == MODE_AUTO) begin
				s_d.psc = RST_PSC;
			end
		end
		if (ovf_ev) begin
			s_d.pwm = 1'b1;
		end
		if (cmp_ev) begin
			s_d.pwm = 1'b0;
		end

		// Pin edge actions win over counting in the same cycle.
		if (edge_ev) begin
			case (mode)
				MODE_CAP: begin
					s_d.reload = s_q.cnt;
				end
				MODE_CAPRST: begin
					s_d.reload = s_q.cnt;
					s_d.cnt    = RST_BYTE;
					s_d.psc    = RST_PSC;
				end
				MODE_EXTLD: begin
					s_d.cnt = s_q.reload;
					s_d.psc = RST_PSC;
				end
				default: begin
				end
			endcase
		end

		// Register writes; software loads win over counting.
		if (wr && paddr_i == addr_of(IDX_CLK_CFG)) begin
			s_d.clk_cfg = pwdata_i[7:0] & CC_WR_MASK;
		end
		if (wr && paddr_i == addr_of(IDX_RELOAD)) begin
			s_d.reload = pwdata_i[7:0];
		end
		if (wr && paddr_i == addr_of(IDX_COMPARE)) begin
			s_d.compare = pwdata_i[7:0];
		end
		if (wr_mode) begin
			s_d.mode_ctrl = pwdata_i[7:0] & MC_RD_MASK;
		end
		if (do_cmd_load) begin
			s_d.cnt = s_q.reload;
			s_d.psc = RST_PSC;
		end
		if (wr_load) begin
			s_d.cnt = pwdata_i[7:0];
			s_d.psc = RST_PSC;
		end

		// Flags: a zero clears, a one keeps, and a new event always wins.
		if (wr_flags) begin
			s_d.flags = s_q.flags & pwdata_i[2:0];
		end
		if (ovf_ev) begin
			s_d.flags[FL_OVF] = 1'b1;
		end
		if (cmp_ev) begin
			s_d.flags[FL_CPF] = 1'b1;
		end
		if (edge_ev) begin
			s_d.flags[FL_EF] = 1'b1;
		end

		// Read data is captured in the setup phase for a zero-wait answer.
		if (psel_i && !penable_i && !pwrite_i) begin
			s_d.prdata = {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata_o            = s_q.prdata;
	assign pwm_output_pin_oe_o = s_q.mode_ctrl[MC_PWMOE];
	assign pwm_output_pin_o    = s_q.mode_ctrl[MC_PWMOE] && s_q.pwm;
	assign irq_o = (s_q.flags[FL_OVF] && s_q.mode_ctrl[MC_OVERFLOW_IRQ_ENABLE]) ||
		(s_q.flags[FL_CPF] && s_q.mode_ctrl[MC_COMPARE_IRQ_ENABLE]) ||
		(s_q.flags[FL_EF] && s_q.mode_ctrl[MC_EIE]);
	assign wake_o = irq_o && (wait_mode_i || (stop_mode_i && src == SRC_PIN));

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	load_write_a: assert property (wr_load |=>
		s_q.cnt == $past(pwdata_i[7:0]) && s_q.psc == RST_PSC)
		else $error("load write not copied");
	load_read_a: assert property (psel_i && !penable_i && !pwrite_i &&
		paddr_i == addr_of(IDX_LOAD) |=> prdata_o[7:0] == $past(s_q.cnt))
		else $error("load read wrong");
	freeze_hold_a: assert property (!s_q.mode_ctrl[MC_TEN] && !wr && !edge_ev |=>
		$stable(s_q.cnt) && $stable(s_q.psc)) else $error("disabled timer moved");
	ovf_flag_a: assert property (ovf_ev |=>
		s_q.flags[FL_OVF] && s_q.pwm == !$past(cmp_ev)) else $error("overflow not flagged");
	cmp_flag_a: assert property (cmp_ev |=> s_q.flags[FL_CPF] && !s_q.pwm)
		else $error("compare not flagged");
	irq_ovf_a: assert property (s_q.flags[FL_OVF] && s_q.mode_ctrl[MC_OVERFLOW_IRQ_ENABLE] |-> irq_o)
		else $error("overflow irq missing");
	irq_cmp_a: assert property (s_q.flags[FL_CPF] && s_q.mode_ctrl[MC_COMPARE_IRQ_ENABLE] |-> irq_o)
		else $error("compare irq missing");
	irq_ext_a: assert property (s_q.flags[FL_EF] && s_q.mode_ctrl[MC_EIE] |-> irq_o)
		else $error("external irq missing");
	capture_a: assert property (edge_ev && mode == MODE_CAP && !wr |=>
		s_q.reload == $past(s_q.cnt) && s_q.flags[FL_EF]) else $error("capture lost");
	cap_reset_a: assert property (edge_ev && mode == MODE_CAPRST && !wr |=>
		s_q.cnt == RST_BYTE && s_q.psc == RST_PSC) else $error("capture reset lost");
	ext_load_a: assert property (edge_ev && mode == MODE_EXTLD && !wr |=>
		s_q.cnt == $past(s_q.reload)) else $error("external load lost");
	ef_keep_a: assert property (wr_flags && pwdata_i[2:0] == 3'h6 &&
		s_q.flags[FL_EF] |=> s_q.flags[FL_EF] && (!s_q.flags[FL_OVF] || $past(ovf_ev)))
		else $error("flag clear wrong");
	reload_a: assert property (ovf_ev && mode == MODE_AUTO && !wr |=>
		s_q.cnt == $past(s_q.reload) && s_q.psc == RST_PSC) else $error("no reload");
	cmd_load_a: assert property (do_cmd_load |=>
		s_q.cnt == $past(s_q.reload) && s_q.psc == RST_PSC) else $error("load command lost");
	count_step_a: assert property (tick && !ovf_ev && !wr && !edge_ev |=>
		s_q.cnt == 8'($past(s_q.cnt) + CNT_ONE)) else $error("count step wrong");
	edge_once_a: assert property (edge_ev && !wr |=> !edge_ev)
		else $error("edge event too long");
	edge_off_a: assert property (!s_q.clk_cfg[CC_EDGE] && !wr |=>
		$stable(s_q.flags[FL_EF])) else $error("disabled edge flagged");
	wake_wait_a: assert property (irq_o && wait_mode_i |-> wake_o)
		else $error("wait wake missing");
endmodule // art_timer

//--- tb/art_pin_src.sv
// Purpose: Timing signal source that drives the timer input pin.
// Assumes: One clock; the level changes only right after a rising edge.
// Notes:   Runs as a free clock of eight cycles per period only while run_i is high.
`timescale 1ns/1ns
module art_pin_src (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Control and pin.
	input  wire logic run_i,
	input  wire logic lvl_i,
	output logic      pin_o
);
	logic [1:0] ph_q;

	// The pin clock stands still outside a run and then follows the requested level.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ph_q  <= 2'h0;
			pin_o <= 1'b0;
		end else if (run_i) begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h3) begin
				pin_o <= ~pin_o;
			end
		end else begin
			ph_q  <= 2'h0;
			pin_o <= lvl_i;
		end
	end
endmodule // art_pin_src

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the auto-reload PWM/capture timer.
// Assumes: Zero-wait APB slave; pin edges seen three cycles late.
// Notes:   Counts are checked over windows that hold a whole number of ticks.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	import art_pkg::*;
	logic          clk_i = 1'b0;
	logic          rst_b_i = 1'b0;
	logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [AW-1:0] paddr = '0;
	logic [DW-1:0] pwdata = '0;
	logic [DW-1:0] prdata, rd;
	logic          pready, pslverr, pin, err, pwm, pwm_oe, irq, wake;
	logic          run = 1'b0, lvl = 1'b0, wait_m = 1'b0, stop_m = 1'b0;
	logic [7:0]    rnd = 8'h0c;
	logic [7:0]    regs [6] = '{IDX_MODE_CTRL, IDX_FLAGS, IDX_CLK_CFG, IDX_RELOAD,
		IDX_COMPARE, IDX_LOAD};
	int            fails = 0, checked = 0;

	always #10 clk_i = ~clk_i;

	art_timer DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .timer_input_pin_i(pin),
		.pwm_output_pin_o(pwm), .pwm_output_pin_oe_o(pwm_oe), .wait_mode_i(wait_m),
		.stop_mode_i(stop_m), .irq_o(irq), .wake_o(wake));
	art_pin_src SRC (.clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run), .lvl_i(lvl), .pin_o(pin));

	// ****************
	// Helpers
	// ****************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge clk_i);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			fails++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task clks(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// ****************
	// Scenarios
	// ****************
	initial begin
		int m, n, k, src, w;
		logic [7:0] c;
		logic [2:0] f;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (m = 0; m < 6; m++) begin
			apb(1'b0, regs[m], 8'h00);
			`CHK(rd, 32'h0)
		end
		apb(1'b0, 8'h00, 8'h00);
		`CHK({err, rd}, 33'h1_0000_0000)
		for (m = 0; m < 6; m++) begin
			src = m % 3;
			rnd = lfsr(rnd);
			n = rnd % 3;
			k = 3 + rnd[6:4];
			w = (k << n) * (src == 0 ? 1 : src == 1 ? 3 : 8);
			apb(1'b1, IDX_MODE_CTRL, 8'h00);
			apb(1'b1, IDX_CLK_CFG, {n[2:0], 3'h0, src[1:0]});
			run <= (src == 2);
			apb(1'b1, IDX_LOAD, rnd);
			apb(1'b1, IDX_MODE_CTRL, 8'h40);
			apb(1'b0, IDX_LOAD, 8'h00);
			c = rd[7:0];
			// Each read samples the count two edges after it starts, so w - 3 idle edges
			// leave exactly w counting edges between the two samples.
			clks(w - 3);
			apb(1'b0, IDX_LOAD, 8'h00);
			`CHK(rd[7:0] - c, k[7:0])
		end
		run <= 1'b0;
		apb(1'b1, IDX_MODE_CTRL, 8'h00);
		apb(1'b1, IDX_LOAD, rnd);
		apb(1'b0, IDX_LOAD, 8'h00);
		`CHK(rd[7:0], rnd)
		clks(9);
		apb(1'b0, IDX_LOAD, 8'h00);
		`CHK(rd[7:0], rnd)
		apb(1'b1, IDX_CLK_CFG, 8'h00);
		apb(1'b1, IDX_RELOAD, 8'hf0);
		apb(1'b1, IDX_COMPARE, 8'hf8);
		apb(1'b1, IDX_FLAGS, 8'h00);
		apb(1'b1, IDX_MODE_CTRL, 8'hec);
		rnd = lfsr(rnd);
		clks(20 + rnd[5:0]);
		apb(1'b1, IDX_MODE_CTRL, 8'h2c);
		apb(1'b0, IDX_LOAD, 8'h00);
		c = rd[7:0];
		`CHK(c >= 8'hf0, 1'b1)
		`CHK(pwm, c < 8'hf8)
		`CHK(pwm_oe, 1'b1)
		apb(1'b0, IDX_FLAGS, 8'h00);
		f = rd[2:0];
		`CHK(f[1:0], 2'h3)
		`CHK(irq, 1'b1)
		wait_m <= 1'b1;
		clks(1);
		#1 `CHK(wake, 1'b1)
		@(posedge clk_i);
		wait_m <= 1'b0;
		stop_m <= 1'b1;
		clks(1);
		#1 `CHK(wake, 1'b0)
		@(posedge clk_i);
		stop_m <= 1'b0;
		apb(1'b1, IDX_FLAGS, 8'h06);
		apb(1'b0, IDX_FLAGS, 8'h00);
		`CHK(rd[2:0], {f[2], f[1], 1'b0})
		apb(1'b1, IDX_FLAGS, 8'h00);
		#1 `CHK(irq, 1'b0)
		for (m = 0; m < 4; m++) begin
			lvl <= m[0];
			rnd = lfsr(rnd);
			c = rnd | 8'h80;
			apb(1'b1, IDX_MODE_CTRL, {6'h04, m[1:0]});
			apb(1'b1, IDX_RELOAD, 8'h33);
			apb(1'b1, IDX_LOAD, c);
			apb(1'b1, IDX_FLAGS, 8'h00);
			apb(1'b1, IDX_CLK_CFG, {4'h0, m[0], 3'h4});
			lvl <= ~m[0];
			clks(6);
			apb(1'b0, IDX_RELOAD, 8'h00);
			`CHK(rd[7:0], (m == 1 || m == 2) ? c : 8'h33)
			apb(1'b0, IDX_LOAD, 8'h00);
			`CHK(rd[7:0], m == 2 ? 8'h00 : m == 3 ? 8'h33 : c)
			apb(1'b0, IDX_FLAGS, 8'h00);
			`CHK({irq, rd[2]}, 2'h3)
			apb(1'b1, IDX_FLAGS, 8'h06);
			apb(1'b0, IDX_FLAGS, 8'h00);
			`CHK(rd[2:0], 3'h4)
		end
		apb(1'b1, IDX_FLAGS, 8'h00);
		apb(1'b1, IDX_CLK_CFG, 8'h00);
		lvl <= 1'b1;
		clks(6);
		apb(1'b0, IDX_FLAGS, 8'h00);
		`CHK(rd[2], 1'b0)
		report_and_stop();
	end
endmodule // tb_top
